// file: tcl_ctrl_load.sv
// tuner control-load block: host staging port, control registers, serial ports, test pins
// assumes host pins are asynchronous; serial pins and load strobe launch from ref_clk_i
//
// How it works
// (RULE1) two independent serial ports load carrier and sample offset words
// (RULE2) each port samples its serial data pin every clock while shifting
// (RULE3) serial word length is 8, 16, 24 or 32 from chip configuration
// (RULE4) source raises word sync for the clock before the first bit
// (RULE5) sync starts a down-count; at its end the word moves to the port output register
// (RULE6) shift register accepts new data the clock after a transfer
// (RULE7) short words are left-aligned, unused low bits cleared
// (RULE8) source sends MSB first and holds sync for one clock only
// (RULE9) test mode drives each output pin from its test register bit
// (RULE10) in serial output mode test register sets the unused output pins
// (RULE11) four staging bytes and a select byte on 3-bit address, 8-bit data
// (RULE12) address and data captured on rising edge of write strobe
// (RULE13) staging bytes 0 to 3 supply bits 7-0 up to 31-24
// (RULE14) fourth clock after select write, staging copied into chosen register
// (RULE15) only select bits 3-0 decode the destination
// (RULE16) host can read back sampled gain-loop accumulator over data bus
// (RULE17) host waits 4 clocks after select write before restaging
// (RULE18) frequency-load strobe high copies staging into center frequency register
// (RULE19) select value 9 samples accumulator; read no sooner than 6 clocks later
// (RULE20) staging, shift registers and counters clear on reset, nothing pending
`timescale 1ns/1ps
`default_nettype none
module tcl_ctrl_load #(
    parameter int          OUT_W         = 20,
    parameter logic [31:0] SER_USED_MASK = 32'h00000201
) (
    input  wire logic                                     ref_clk_i,
    input  wire logic                                     sys_rst_i,
    input  wire logic [tcl_pkg::ADDR_W-1:0]               host_addr_bus_i,
    input  wire logic [tcl_pkg::DATA_W-1:0]               host_data_bus_i,
    output logic      [tcl_pkg::DATA_W-1:0]               host_data_bus_o,
    output logic                                          host_data_bus_oe_o,
    input  wire logic                                     host_wr_n_i,
    input  wire logic                                     host_rd_n_i,
    input  wire logic                                     freq_load_strobe_i,
    input  wire logic                                     carrier_offset_serial_in_i,
    input  wire logic                                     carrier_offset_word_sync_i,
    input  wire logic                                     sample_offset_serial_in_i,
    input  wire logic                                     sample_offset_word_sync_i,
    input  wire logic [tcl_pkg::DATA_W-1:0]               agc_acc_upper_i,
    input  wire logic [OUT_W-1:0]                         datapath_out_i,
    output logic      [OUT_W-1:0]                         out_pins_o,
    output logic      [tcl_pkg::NUM_CTRL*tcl_pkg::WORD_W-1:0] ctrl_regs_o,
    output tcl_pkg::tcl_serial_word_t                     carrier_offset_o,
    output tcl_pkg::tcl_serial_word_t                     sample_offset_o
);
    import tcl_pkg::*;

    localparam int PIN_N = ADDR_W + DATA_W + 2;

    if (OUT_W < 1 || OUT_W > WORD_W) begin : g_bad_out_w
        $error("OUT_W must lie in 1..32");
    end

    // ****************************************
    // pin resynchronisation
    // ****************************************
    logic [PIN_N-1:0] pin_raw;
    logic [PIN_N-1:0] pin_s1, pin_s2, pin_s3;
    logic [PIN_N-1:0] pin_filt_reg, pin_filt_next;

    assign pin_raw = {host_addr_bus_i, host_data_bus_i, host_wr_n_i, host_rd_n_i};

    for (genvar i = 0; i < PIN_N; i++) begin : g_sync
        always_comb begin
            pin_filt_next[i] = (pin_s2[i] == pin_s3[i]) ? pin_s3[i] : pin_filt_reg[i];
        end
        always_ff @(posedge ref_clk_i) begin
            if (sys_rst_i) begin
                pin_s1[i]       <= 1'b1;
                pin_s2[i]       <= 1'b1;
                pin_s3[i]       <= 1'b1;
                pin_filt_reg[i] <= 1'b1;
            end else begin
                pin_s1[i]       <= pin_raw[i];
                pin_s2[i]       <= pin_s1[i];
                pin_s3[i]       <= pin_s2[i];
                pin_filt_reg[i] <= pin_filt_next[i];
            end
        end
    end

    tcl_host_wr_t host_in;
    logic         wr_n_lvl, rd_n_lvl, fld_lvl;
    logic         cof_d, cof_s, sof_d, sof_s;
    logic         wr_n_prev_reg;
    logic         wr_edge;

    assign {host_in, wr_n_lvl, rd_n_lvl} = pin_filt_reg;
    // same-clock pins: a one-clock sync or bit would never pass the agree filter
    assign fld_lvl = freq_load_strobe_i;
    assign cof_d   = carrier_offset_serial_in_i;
    assign cof_s   = carrier_offset_word_sync_i;
    assign sof_d   = sample_offset_serial_in_i;
    assign sof_s   = sample_offset_word_sync_i;
    assign wr_edge = wr_n_lvl && !wr_n_prev_reg;     // see RULE12

    // ****************************************
    // staging, destination and transfer
    // ****************************************
    logic [DATA_W-1:0] stage_reg [4];
    logic [DATA_W-1:0] stage_next [4];
    logic [WORD_W-1:0] ctrl_reg [NUM_CTRL];
    logic [WORD_W-1:0] ctrl_next [NUM_CTRL];
    logic [DEST_W-1:0] dest_reg,    dest_next;
    logic [2:0]        xfer_cnt_reg, xfer_cnt_next;
    logic [DATA_W-1:0] acc_reg,     acc_next;
    logic [WORD_W-1:0] staged_word;
    logic              target_wr;
    logic              copy_now;

    assign staged_word = {stage_reg[3], stage_reg[2], stage_reg[1], stage_reg[0]}; // see RULE13
    assign target_wr   = wr_edge && host_in.addr == TARGET_SELECT_OFS;             // see RULE11
    assign copy_now    = xfer_cnt_reg == 3'h1;

    always_comb begin
        stage_next    = stage_reg;
        ctrl_next     = ctrl_reg;
        dest_next     = dest_reg;
        xfer_cnt_next = xfer_cnt_reg;
        acc_next      = acc_reg;
        if (wr_edge && host_in.addr < TARGET_SELECT_OFS) begin
            stage_next[host_in.addr[1:0]] = host_in.data;                           // see RULE12
        end
        if (xfer_cnt_reg != 3'h0) begin
            xfer_cnt_next = xfer_cnt_reg - 3'h1;
        end
        if (copy_now) begin
            if (dest_reg < DEST_W'(NUM_CTRL)) begin
                ctrl_next[dest_reg] = staged_word;                                  // see RULE14
            end else if (dest_reg == DEST_ACC_SAMPLE) begin
                acc_next = agc_acc_upper_i;                                         // see RULE19
            end
        end
        if (fld_lvl) begin
            ctrl_next[DEST_CENTER_FREQ] = staged_word;                              // see RULE18
        end
        if (target_wr) begin
            dest_next     = host_in.data[DEST_W-1:0];                               // see RULE15
            xfer_cnt_next = XFER_DELAY;                                             // see RULE14
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            for (int k = 0; k < 4; k++) begin
                stage_reg[k] <= STAGE_RST;                                          // see RULE20
            end
            for (int k = 0; k < NUM_CTRL; k++) begin
                ctrl_reg[k] <= CTRL_RST;
            end
            dest_reg      <= '0;
            xfer_cnt_reg  <= '0;
            acc_reg       <= '0;
            wr_n_prev_reg <= 1'b1;
        end else begin
            stage_reg     <= stage_next;
            ctrl_reg      <= ctrl_next;
            dest_reg      <= dest_next;
            xfer_cnt_reg  <= xfer_cnt_next;
            acc_reg       <= acc_next;
            wr_n_prev_reg <= wr_n_lvl;
        end
    end

    for (genvar r = 0; r < NUM_CTRL; r++) begin : g_ctrl_out
        assign ctrl_regs_o[r*WORD_W +: WORD_W] = ctrl_reg[r];
    end

    // ****************************************
    // read-back and output pins
    // ****************************************
    logic [DATA_W-1:0] rd_data_reg, rd_data_next;
    logic              rd_oe_reg,   rd_oe_next;
    logic [OUT_W-1:0]  pins_reg,    pins_next;
    logic [OUT_W-1:0]  test_bits;
    logic [OUT_W-1:0]  used_mask;
    logic              test_en, ser_out;

    assign test_bits = ctrl_reg[DEST_TEST][OUT_W-1:0];
    assign used_mask = SER_USED_MASK[OUT_W-1:0];
    assign test_en   = ctrl_reg[DEST_CHIP_CFG][CFG_TEST_EN_BIT];
    assign ser_out   = ctrl_reg[DEST_CHIP_CFG][CFG_SER_OUT_BIT];

    always_comb begin
        rd_oe_next   = !rd_n_lvl;                                                   // see RULE16
        rd_data_next = acc_reg;
        if (test_en) begin
            pins_next = test_bits;                                                  // see RULE9
        end else if (ser_out) begin
            pins_next = (datapath_out_i & used_mask) | (test_bits & ~used_mask);    // see RULE10
        end else begin
            pins_next = datapath_out_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            rd_oe_reg   <= 1'b0;
            rd_data_reg <= '0;
            pins_reg    <= '0;
        end else begin
            rd_oe_reg   <= rd_oe_next;
            rd_data_reg <= rd_data_next;
            pins_reg    <= pins_next;
        end
    end

    assign host_data_bus_o    = rd_data_reg;
    assign host_data_bus_oe_o = rd_oe_reg;
    assign out_pins_o         = pins_reg;

    // ****************************************
    // serial frequency ports
    // ****************************************
    logic [1:0] width_code;
    assign width_code = ctrl_reg[DEST_CHIP_CFG][CFG_SER_WIDTH_LSB +: 2];           // see RULE3

    tcl_serial_port u_carrier_port (                                                // see RULE1
        .ref_clk_i    (ref_clk_i),
        .sys_rst_i    (sys_rst_i),
        .ser_data_i   (cof_d),
        .word_sync_i  (cof_s),
        .width_code_i (width_code),
        .word_o       (carrier_offset_o)
    );

    tcl_serial_port u_sample_port (                                                 // see RULE1
        .ref_clk_i    (ref_clk_i),
        .sys_rst_i    (sys_rst_i),
        .ser_data_i   (sof_d),
        .word_sync_i  (sof_s),
        .width_code_i (width_code),
        .word_o       (sample_offset_o)
    );

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    chk_select_fourth_clock: assert property ( // see RULE14
        target_wr ##1 !target_wr[*4] |-> copy_now
    ) else $error("staging copy not due on fourth clock after select write");

    chk_copy_sampler_word: assert property ( // see RULE14
        copy_now && dest_reg == DEST_SAMPLER_FREQ |=> ctrl_reg[1] == $past(staged_word)
    ) else $error("sampler register not loaded from staging");

    chk_stage_byte_write: assert property ( // see RULE12
        wr_edge && host_in.addr == STAGE_BYTE2_OFS |=> staged_word[23:16] == $past(host_in.data)
    ) else $error("staging byte 2 not captured on write edge");

    chk_dest_low_bits: assert property ( // see RULE15
        target_wr |=> dest_reg == $past(host_in.data[3:0]) && xfer_cnt_reg == XFER_DELAY
    ) else $error("destination decode not from low nibble");

    chk_freq_load_copy: assert property ( // see RULE18
        fld_lvl |=> ctrl_reg[0] == $past(staged_word)
    ) else $error("frequency load strobe did not copy staging");

    chk_acc_sample_take: assert property ( // see RULE19
        copy_now && dest_reg == DEST_ACC_SAMPLE |=> acc_reg == $past(agc_acc_upper_i)
    ) else $error("accumulator not sampled on select 9");

    chk_read_drive_bus: assert property ( // see RULE16
        !rd_n_lvl ##1 !rd_n_lvl |-> host_data_bus_oe_o && host_data_bus_o == $past(acc_reg)
    ) else $error("read strobe did not drive accumulator sample");

    chk_test_force_pins: assert property ( // see RULE9
        test_en |=> out_pins_o == $past(test_bits)
    ) else $error("test mode pins not forced from test register");

    chk_ser_unused_pins: assert property ( // see RULE10
        !test_en && ser_out |=> (out_pins_o & ~$past(used_mask)) == ($past(test_bits) & ~$past(used_mask))
    ) else $error("unused serial-mode pins not set by test register");

    cov_select_copy:   cover property (copy_now && dest_reg == DEST_CENTER_FREQ);
    cov_freq_load:     cover property (fld_lvl);
    cov_acc_read:      cover property (copy_now && dest_reg == DEST_ACC_SAMPLE ##[6:20] !rd_n_lvl);
    cov_carrier_word:  cover property (carrier_offset_o.valid);

endmodule // tcl_ctrl_load
`default_nettype wire

// file: tcl_ctrl_load_tb_top.sv
// self-checking bench of the tuner control-load block against a reference model
// assumes tcl_pkg, the design and the serial source model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tcl_ctrl_load_tb_top;
    import tcl_pkg::*;
    localparam int          OW   = 20;
    localparam logic [31:0] MASK = 32'h000F0F0F;
    logic                       ref_clk_i = 1'b0;
    logic                       sys_rst_i = 1'b1;
    logic [ADDR_W-1:0]          addr      = 3'h0;
    logic [DATA_W-1:0]          wdata     = 8'h00;
    logic [DATA_W-1:0]          acc       = 8'h00;
    logic [DATA_W-1:0]          acc_exp;
    logic [DATA_W-1:0]          rdata;
    logic                       oe;
    logic                       wr_n      = 1'b1;
    logic                       rd_n      = 1'b1;
    logic                       freq_load_strobe      = 1'b0;
    logic                       a_dat, a_syn, b_dat, b_syn;
    logic [OW-1:0]              dp        = 20'h00000;
    logic [OW-1:0]              pins;
    logic [NUM_CTRL*WORD_W-1:0] regs;
    tcl_serial_word_t           co, so;
    logic [31:0]                exp_ctrl [NUM_CTRL];
    logic [31:0]                qa [$];
    logic [31:0]                qb [$];
    logic [7:0]                 stg [4];
    logic [31:0]                t, m, w0, w1, w2;
    int                         num_errors = 0;
    int                         checks     = 0;
    int                         seed       = 51;

    always #2 ref_clk_i = ~ref_clk_i;

    tcl_ctrl_load #(.OUT_W(OW), .SER_USED_MASK(MASK)) dut (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .host_addr_bus_i(addr),
        .host_data_bus_i(wdata), .host_data_bus_o(rdata), .host_data_bus_oe_o(oe),
        .host_wr_n_i(wr_n), .host_rd_n_i(rd_n), .freq_load_strobe_i(freq_load_strobe),
        .carrier_offset_serial_in_i(a_dat), .carrier_offset_word_sync_i(a_syn),
        .sample_offset_serial_in_i(b_dat), .sample_offset_word_sync_i(b_syn),
        .agc_acc_upper_i(acc), .datapath_out_i(dp), .out_pins_o(pins),
        .ctrl_regs_o(regs), .carrier_offset_o(co), .sample_offset_o(so));
    tcl_ser_src src_a (.clk_i(ref_clk_i), .data_o(a_dat), .sync_o(a_syn));
    tcl_ser_src src_b (.clk_i(ref_clk_i), .data_o(b_dat), .sync_o(b_syn));

    // ************************************************************
    // comparison, verdict and host bus tasks
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    task automatic hwr(input logic [2:0] a, input logic [7:0] d);
        addr  = a;
        wdata = d;
        wr_n  = 1'b0;
        cyc(4);
        wr_n  = 1'b1;
        cyc(5);
        wdata = 8'($random(seed));
        cyc(1);
        if (a < 3'h4) stg[a[1:0]] = d;
    endtask

    task automatic stage(input logic [31:0] w);
        for (int i = 0; i < 4; i++) hwr(3'(i), w[8*i +: 8]);
    endtask

    task automatic sel(input logic [3:0] d);
        hwr(3'h4, {4'($random(seed)), d});
        cyc(6);
        if (d < 4'h9) exp_ctrl[d] = {stg[3], stg[2], stg[1], stg[0]};
    endtask

    task automatic cmp_all();
        for (int r = 0; r < NUM_CTRL; r++) check(regs[r*32 +: 32], exp_ctrl[r], "ctrl");
    endtask

    task automatic load(input logic [3:0] d, input logic [31:0] w);
        stage(w);
        sel(d);
        cmp_all();
    endtask

    // serial words are compared whenever a port reports one
    always @(posedge ref_clk_i) begin
        if (co.valid === 1'b1) check(co.word, (qa.size() > 0) ? qa.pop_front() : 32'hX, "cof");
        if (so.valid === 1'b1) check(so.word, (qb.size() > 0) ? qb.pop_front() : 32'hX, "sof");
    end

    initial begin
        repeat (20000) @(posedge ref_clk_i);
        num_errors++;
        conclude();
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        for (int r = 0; r < NUM_CTRL; r++) exp_ctrl[r] = 32'h00000000;
        for (int i = 0; i < 4; i++) stg[i] = 8'h00;
        dp = OW'($random(seed));
        cyc(20);
        cmp_all();
        check(32'(oe), 32'h0, "oe in reset");
        check(32'(pins), 32'h0, "pins in reset");
        sys_rst_i = 1'b0;
        cyc(2);
        for (int d = 0; d < 16; d++)
            if (d != 5 && d != 9) load(4'(d), 32'($random(seed)));
        stage(32'($random(seed)));
        for (int a = 5; a < 8; a++) hwr(3'(a), 8'($random(seed)));
        sel(4'h1);
        cmp_all();
        stage(32'($random(seed)));
        cyc(2);
        freq_load_strobe = 1'b1;
        cyc(3);
        freq_load_strobe = 1'b0;
        cyc(4);
        exp_ctrl[0] = {stg[3], stg[2], stg[1], stg[0]};
        cmp_all();
        acc     = 8'($random(seed));
        acc_exp = acc;
        sel(4'h9);
        acc  = ~acc_exp;
        rd_n = 1'b0;
        for (int i = 0; i < 20 && oe !== 1'b1; i++) cyc(1);
        check(32'(oe), 32'h1, "read enable");
        check(32'(rdata), 32'(acc_exp), "acc sample");
        rd_n = 1'b1;
        cyc(6);
        check(32'(oe), 32'h0, "bus released");
        for (int c = 0; c < 4; c++) begin
            load(4'h5, 32'(c));
            m  = ~(32'hFFFFFFFF >> (8 * (c + 1)));
            w0 = 32'($random(seed));
            w1 = 32'($random(seed));
            w2 = 32'($random(seed));
            qa.push_back(w0 & m);
            qa.push_back(w1 & m);
            qb.push_back(w2 & m);
            fork
                src_a.send(w0, w1, 8 * (c + 1), 2);
                src_b.send(w2, w2, 8 * (c + 1), 1);
            join
            cyc(10);
            check(32'(qa.size() + qb.size()), 32'h0, "words delivered");
        end
        t = 32'($random(seed));
        load(4'h7, t);
        load(4'h5, 32'h00000004);
        check(32'(pins), 32'(t[OW-1:0]), "test pins");
        dp = OW'($random(seed));
        load(4'h5, 32'h00000008);
        check(32'(pins), 32'((dp & MASK[OW-1:0]) | (t[OW-1:0] & ~MASK[OW-1:0])), "ser pins");
        load(4'h5, 32'h00000000);
        check(32'(pins), 32'(dp), "normal pins");
        conclude();
    end
endmodule // tcl_ctrl_load_tb_top
`default_nettype wire

// file: tcl_pkg.sv
// constants, field layouts and carrier types of the tuner control-load block
// assumes one device clock; host pins are resynchronised by the top, serial pins and load strobe are not
package tcl_pkg;

    localparam int ADDR_W      = 3;
    localparam int DATA_W      = 8;
    localparam int WORD_W      = 32;
    localparam int DEST_W      = 4;
    localparam int SYNC_STAGES = 3;

    // host port register offsets
    localparam logic [ADDR_W-1:0] STAGE_BYTE0_OFS   = 3'h0;
    localparam logic [ADDR_W-1:0] STAGE_BYTE1_OFS   = 3'h1;
    localparam logic [ADDR_W-1:0] STAGE_BYTE2_OFS   = 3'h2;
    localparam logic [ADDR_W-1:0] STAGE_BYTE3_OFS   = 3'h3;
    localparam logic [ADDR_W-1:0] TARGET_SELECT_OFS = 3'h4;

    // destination codes
    localparam logic [DEST_W-1:0] DEST_CENTER_FREQ = 4'h0;
    localparam logic [DEST_W-1:0] DEST_SAMPLER_FREQ = 4'h1;
    localparam logic [DEST_W-1:0] DEST_CHIP_CFG    = 4'h5;
    localparam logic [DEST_W-1:0] DEST_TEST        = 4'h7;
    localparam logic [DEST_W-1:0] DEST_ACC_SAMPLE  = 4'h9;
    localparam int                NUM_CTRL         = 9;

    // chip configuration fields
    localparam int CFG_SER_WIDTH_LSB = 0;
    localparam int CFG_TEST_EN_BIT   = 2;
    localparam int CFG_SER_OUT_BIT   = 3;

    // timing counts in device clocks
    localparam logic [2:0] XFER_DELAY     = 3'h4;
    localparam int         ACC_READ_DELAY = 6;

    // reset values
    localparam logic [DATA_W-1:0] STAGE_RST = 8'h00;
    localparam logic [WORD_W-1:0] CTRL_RST  = 32'h00000000;

    typedef struct packed {
        logic              valid;
        logic [WORD_W-1:0] word;
    } tcl_serial_word_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } tcl_host_wr_t;

endpackage

// file: tcl_ser_src.sv
// serial frequency-word source standing in for an external tracking loop
// assumes the bench calls send just after a rising edge of clk_i
`timescale 1ns/1ps
`default_nettype none
module tcl_ser_src (
    input  wire logic clk_i,
    output logic      data_o,
    output logic      sync_o
);
    logic busy;

    initial begin
        data_o = 1'b0;
        sync_o = 1'b0;
        busy   = 1'b0;
    end

    // idle data toggles so a stale bit never looks valid
    always @(posedge clk_i) begin
        #1;
        if (!busy) data_o = ~data_o;
    end

    // ************************************************************
    // word sender: sync one clock ahead, next sync on the last bit
    // ************************************************************
    task automatic send(input logic [31:0] w0, input logic [31:0] w1, input int n, input int cnt);
        logic [31:0] w;
        busy   = 1'b1;
        sync_o = 1'b1;
        for (int k = 0; k < cnt; k++) begin
            w = (k == 0) ? w0 : w1;
            for (int i = 0; i < n; i++) begin
                @(posedge clk_i);
                #1;
                data_o = w[31-i];
                sync_o = (i == n - 1) && (k < cnt - 1);
            end
        end
        @(posedge clk_i);
        #1;
        sync_o = 1'b0;
        busy   = 1'b0;
    endtask
endmodule // tcl_ser_src
`default_nettype wire

// file: tcl_serial_port.sv
// one-wire serial frequency port: sync-started, length-counted, left-aligned word
// assumes data and sync are launched from logic on ref_clk_i
`timescale 1ns/1ps
`default_nettype none
module tcl_serial_port (
    input  wire logic                    ref_clk_i,
    input  wire logic                    sys_rst_i,
    input  wire logic                    ser_data_i,
    input  wire logic                    word_sync_i,
    input  wire logic [1:0]              width_code_i,
    output tcl_pkg::tcl_serial_word_t    word_o
);
    import tcl_pkg::*;

    logic [WORD_W-1:0]  shift_reg,  shift_next;
    logic [5:0]         count_reg,  count_next;
    tcl_serial_word_t   out_reg,    out_next;
    logic [5:0]         word_bits;
    logic [WORD_W-1:0]  shifted;

    assign word_bits = {width_code_i, 3'b000} + 6'd8;   // see RULE3
    assign shifted   = {shift_reg[WORD_W-2:0], ser_data_i};

    always_comb begin
        shift_next     = shift_reg;
        count_next     = count_reg;
        out_next       = out_reg;
        out_next.valid = 1'b0;
        if (count_reg != 6'd0) begin
            shift_next = shifted;                        // see RULE2
            count_next = count_reg - 6'd1;
            if (count_reg == 6'd1) begin
                out_next.word  = shifted << (6'd32 - word_bits); // see RULE7
                out_next.valid = 1'b1;                   // see RULE5
            end
        end
        // sync on the last bit restarts at once; mid-word it drops the word
        if (word_sync_i) begin
            count_next = word_bits;                      // see RULE5
            shift_next = '0;                             // see RULE6
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            shift_reg <= '0;                             // see RULE20
            count_reg <= '0;
            out_reg   <= '0;
        end else begin
            shift_reg <= shift_next;
            count_reg <= count_next;
            out_reg   <= out_next;
        end
    end

    assign word_o = out_reg;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    chk_left_align_zero: assert property ( // see RULE7
        out_reg.valid |-> ((out_reg.word & ~({WORD_W{1'b1}} << (6'd32 - word_bits))) == '0)
    ) else $error("serial word low bits not cleared");

    chk_eight_bit_count: assert property ( // see RULE5
        (word_sync_i && width_code_i == 2'b00) ##1 (!word_sync_i && width_code_i == 2'b00)[*8]
        |=> out_reg.valid
    ) else $error("8-bit serial word not transferred after 8 bits");

    chk_no_early_word: assert property ( // see RULE6
        word_sync_i |=> count_reg == $past(word_bits) && out_reg.valid == $past(count_reg == 6'd1)
    ) else $error("sync did not restart count or finish pending word");

    cov_serial_word: cover property (out_reg.valid);

endmodule // tcl_serial_port
`default_nettype wire
